//--- rtl/iqc_pkg.sv
package iqc_pkg;

   // ----------------------------------------------------------------
   // Sample and setting widths
   // ----------------------------------------------------------------
   localparam int SAMPLE_W = 16;
   localparam int PHASE_W = 9;
   localparam int COEF_W = 12;
   localparam int FRAC_SHIFT = 11;
   localparam int OFF_ALIGN = SAMPLE_W - 1 - FRAC_SHIFT;
   localparam int FIFO_DEPTH = 16;
   localparam int ADDR_W = 6;

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [5:0] IDX_I_PHASE_LOW = 6'h20;
   localparam logic [5:0] IDX_I_PHASE_HIGH = 6'h21;
   localparam logic [5:0] IDX_I_GAIN_LOW = 6'h22;
   localparam logic [5:0] IDX_I_GAIN_HIGH = 6'h23;
   localparam logic [5:0] IDX_I_OFFSET_LOW = 6'h24;
   localparam logic [5:0] IDX_I_OFFSET_HIGH = 6'h25;
   localparam logic [5:0] IDX_Q_PHASE_LOW = 6'h26;
   localparam logic [5:0] IDX_Q_PHASE_HIGH = 6'h27;
   localparam logic [5:0] IDX_Q_GAIN_LOW = 6'h28;
   localparam logic [5:0] IDX_Q_GAIN_HIGH = 6'h29;
   localparam logic [5:0] IDX_Q_OFFSET_LOW = 6'h2a;
   localparam logic [5:0] IDX_Q_OFFSET_HIGH = 6'h2b;
   localparam logic [5:0] IDX_CONTROL = 6'h3e;
   localparam logic [5:0] IDX_STATUS = 6'h3f;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int STAT_SAT_BIT = 0;
   localparam int STAT_LEVEL_LSB = 8;

   // ----------------------------------------------------------------
   // Values after reset
   // ----------------------------------------------------------------
   localparam logic [8:0] RST_PHASE = 9'h000;
   localparam logic [11:0] RST_GAIN = 12'h7ff;
   localparam logic [11:0] RST_OFFSET = 12'h000;
   localparam logic RST_ENABLE = 1'b1;

   typedef struct packed {
      logic signed [SAMPLE_W-1:0] i;
      logic signed [SAMPLE_W-1:0] q;
   } iqc_sample_t;

   typedef struct packed {
      logic signed [PHASE_W-1:0] i_phase;
      logic signed [PHASE_W-1:0] q_phase;
      logic signed [COEF_W-1:0] i_gain;
      logic signed [COEF_W-1:0] q_gain;
      logic signed [COEF_W-1:0] i_offset;
      logic signed [COEF_W-1:0] q_offset;
   } iqc_setting_t;

endpackage : iqc_pkg

//--- rtl/iqc_top.sv
// How it works
// - I out adds Q times I-phase over 2^11
// - I-phase nine bits, MSB in upper register
// - Phase bit 8 taken from address LSB
// - Each phase byte read back separately
// - Q out adds I times Q-phase over 2^11
// - Q-phase signed, same sense as I-phase
// - Gain scales channel by value over 2^11
// - Gain low byte plus upper nibble register
// - Offset over 2^11 added to channel
// - I offset low byte plus high register
// - Q offset uses same split
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/100ps

// ------------------------------------------------------------------
// Sample FIFO
// ------------------------------------------------------------------
module iqc_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH):0] level
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic [PW:0] count;
   logic push;
   logic pop;

   assign in_ready = (count != (PW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem[rd_ptr];
   assign level = count;

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule : iqc_fifo

// ------------------------------------------------------------------
// Transmit I/Q correction
// ------------------------------------------------------------------
module iqc_top
   import iqc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic in_valid,
   output logic in_ready,
   input wire iqc_sample_t in_sample,
   output logic out_valid,
   input wire logic out_ready,
   output iqc_sample_t out_sample
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   iqc_setting_t cfg;
   logic enable;
   logic sat_flag;
   logic rd_done;
   logic wr_ok;
   logic adv;
   logic fifo_in_ready;
   logic [$clog2(FIFO_DEPTH):0] fifo_level;
   logic v1;
   logic v2;
   logic v3;
   iqc_sample_t s1;
   iqc_sample_t s2;
   iqc_sample_t s3;
   iqc_sample_t next_s1;
   iqc_sample_t next_s2;
   iqc_sample_t next_s3;
   logic [5:0] next_sat;
   logic [31:0] next_readdata;

   // ---------------------------------------------------------------
   // Saturation to full-scale sample limits
   // ---------------------------------------------------------------
   function automatic logic signed [SAMPLE_W-1:0] sat(
      input logic signed [31:0] v,
      output logic hit
   );
      logic signed [31:0] hi;
      logic signed [31:0] lo;
      hi = 32'sd32767;
      lo = -32'sd32768;
      hit = 1'b0;
      if (v > hi) begin
         hit = 1'b1;
         sat = SAMPLE_W'(hi);
      end else if (v < lo) begin
         hit = 1'b1;
         sat = SAMPLE_W'(lo);
      end else begin
         sat = SAMPLE_W'(v);
      end
   endfunction : sat

   // ---------------------------------------------------------------
   // Avalon slave handshake
   // ---------------------------------------------------------------
   assign avs_waitrequest = avs_read & ~rd_done;
   assign wr_ok = avs_write & avs_byteenable[0];

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rd_done <= 1'b0;
      end else begin
         rd_done <= avs_read & ~rd_done;
      end
   end

   // ---------------------------------------------------------------
   // Register writes
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cfg.i_phase <= RST_PHASE;
         cfg.q_phase <= RST_PHASE;
         cfg.i_gain <= RST_GAIN;
         cfg.q_gain <= RST_GAIN;
         cfg.i_offset <= RST_OFFSET;
         cfg.q_offset <= RST_OFFSET;
         enable <= RST_ENABLE;
      end else if (wr_ok) begin
         unique case (avs_address)
            IDX_I_PHASE_LOW, IDX_I_PHASE_HIGH: begin
               cfg.i_phase <= {avs_address[0], avs_writedata[7:0]};
            end
            IDX_Q_PHASE_LOW, IDX_Q_PHASE_HIGH: begin
               cfg.q_phase <= {avs_address[0], avs_writedata[7:0]};
            end
            IDX_I_GAIN_LOW: cfg.i_gain[7:0] <= avs_writedata[7:0];
            IDX_I_GAIN_HIGH: cfg.i_gain[11:8] <= avs_writedata[3:0];
            IDX_Q_GAIN_LOW: cfg.q_gain[7:0] <= avs_writedata[7:0];
            IDX_Q_GAIN_HIGH: cfg.q_gain[11:8] <= avs_writedata[3:0];
            IDX_I_OFFSET_LOW: begin
               cfg.i_offset[7:0] <= avs_writedata[7:0];
            end
            IDX_I_OFFSET_HIGH: begin
               cfg.i_offset[11:8] <= avs_writedata[3:0];
            end
            IDX_Q_OFFSET_LOW: begin
               cfg.q_offset[7:0] <= avs_writedata[7:0];
            end
            IDX_Q_OFFSET_HIGH: begin
               cfg.q_offset[11:8] <= avs_writedata[3:0];
            end
            IDX_CONTROL: enable <= avs_writedata[CTRL_ENABLE_BIT];
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Register reads
   // ---------------------------------------------------------------
   always_comb begin
      next_readdata = 32'h0000_0000;
      unique case (avs_address)
         IDX_I_PHASE_LOW: next_readdata[7:0] = cfg.i_phase[7:0];
         IDX_I_PHASE_HIGH: next_readdata[0] = cfg.i_phase[8];
         IDX_Q_PHASE_LOW: next_readdata[7:0] = cfg.q_phase[7:0];
         IDX_Q_PHASE_HIGH: next_readdata[0] = cfg.q_phase[8];
         IDX_I_GAIN_LOW: next_readdata[7:0] = cfg.i_gain[7:0];
         IDX_I_GAIN_HIGH: next_readdata[3:0] = cfg.i_gain[11:8];
         IDX_Q_GAIN_LOW: next_readdata[7:0] = cfg.q_gain[7:0];
         IDX_Q_GAIN_HIGH: next_readdata[3:0] = cfg.q_gain[11:8];
         IDX_I_OFFSET_LOW: next_readdata[7:0] = cfg.i_offset[7:0];
         IDX_I_OFFSET_HIGH: next_readdata[3:0] = cfg.i_offset[11:8];
         IDX_Q_OFFSET_LOW: next_readdata[7:0] = cfg.q_offset[7:0];
         IDX_Q_OFFSET_HIGH: next_readdata[3:0] = cfg.q_offset[11:8];
         IDX_CONTROL: next_readdata[CTRL_ENABLE_BIT] = enable;
         IDX_STATUS: begin
            next_readdata[STAT_SAT_BIT] = sat_flag;
            next_readdata[STAT_LEVEL_LSB +: 5] = fifo_level;
         end
         default: next_readdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && !rd_done) begin
         avs_readdata <= next_readdata;
      end
   end

   // ---------------------------------------------------------------
   // Datapath stage arithmetic
   // ---------------------------------------------------------------
   always_comb begin
      logic signed [31:0] pi;
      logic signed [31:0] pq;
      logic signed [31:0] gi;
      logic signed [31:0] gq;
      logic signed [31:0] oi;
      logic signed [31:0] oq;
      gi = 32'sd0;
      gq = 32'sd0;
      oi = 32'sd0;
      oq = 32'sd0;
      pi = 32'(in_sample.q) * 32'(cfg.i_phase);
      pq = 32'(in_sample.i) * 32'(cfg.q_phase);
      pi = 32'(in_sample.i) + (pi >>> FRAC_SHIFT);
      pq = 32'(in_sample.q) + (pq >>> FRAC_SHIFT);
      next_s1.i = sat(pi, next_sat[0]);
      next_s1.q = sat(pq, next_sat[1]);
      if (!enable) begin
         next_s1 = in_sample;
         next_sat[1:0] = 2'b00;
      end
      gi = (32'(s1.i) * 32'(cfg.i_gain)) >>> FRAC_SHIFT;
      gq = (32'(s1.q) * 32'(cfg.q_gain)) >>> FRAC_SHIFT;
      next_s2.i = sat(gi, next_sat[2]);
      next_s2.q = sat(gq, next_sat[3]);
      if (!enable) begin
         next_s2 = s1;
         next_sat[3:2] = 2'b00;
      end
      oi = 32'(s2.i) + (32'(cfg.i_offset) <<< OFF_ALIGN);
      oq = 32'(s2.q) + (32'(cfg.q_offset) <<< OFF_ALIGN);
      next_s3.i = sat(oi, next_sat[4]);
      next_s3.q = sat(oq, next_sat[5]);
      if (!enable) begin
         next_s3 = s2;
         next_sat[5:4] = 2'b00;
      end
   end

   // ---------------------------------------------------------------
   // Pipeline: phase, then gain, then offset
   // ---------------------------------------------------------------
   assign adv = fifo_in_ready;
   assign in_ready = adv;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         v1 <= 1'b0;
         v2 <= 1'b0;
         v3 <= 1'b0;
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end else if (adv) begin
         v1 <= in_valid;
         v2 <= v1;
         v3 <= v2;
         s1 <= next_s1;
         s2 <= next_s2;
         s3 <= next_s3;
      end
   end

   // ---------------------------------------------------------------
   // Sticky saturation flag, write one to clear, set wins
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         sat_flag <= 1'b0;
      end else if (adv && ((in_valid && |next_sat[1:0])
                           || (v1 && |next_sat[3:2])
                           || (v2 && |next_sat[5:4]))) begin
         sat_flag <= 1'b1;
      end else if (wr_ok && avs_address == IDX_STATUS
                   && avs_writedata[STAT_SAT_BIT]) begin
         sat_flag <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Output buffer
   // ---------------------------------------------------------------
   iqc_fifo #(
      .WIDTH($bits(iqc_sample_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .in_valid(v3 & adv),
      .in_ready(fifo_in_ready),
      .in_data(s3),
      .out_valid(out_valid),
      .out_ready(out_ready),
      .out_data(out_sample),
      .level(fifo_level)
   );

endmodule : iqc_top

//--- testbench/iqc_top_props.sv
`timescale 1ns/100ps
// ------------
// Port checker
// ------------
module iqc_top_props
   import iqc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic in_valid,
   input wire logic in_ready,
   input wire logic out_valid,
   input wire logic out_ready,
   input wire iqc_sample_t out_sample
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   sequence s_rd_wait;
      avs_read && avs_waitrequest;
   endsequence
   sequence s_rd_done;
      avs_read && !avs_waitrequest;
   endsequence
   AST_WR_NO_WAIT: assert property (avs_write |-> !avs_waitrequest)
      else $error("write stalled");
   AST_IDLE_NO_WAIT: assert property (!avs_read |-> !avs_waitrequest)
      else $error("wait without read");
   AST_RD_ONE_WAIT: assert property (s_rd_wait ##1 avs_read
      |-> !avs_waitrequest) else $error("read wait too long");
   AST_RD_NEW_WAIT: assert property (s_rd_done ##1 avs_read
      |-> avs_waitrequest) else $error("read answered too soon");
   AST_RD_HOLD: assert property (!avs_read |=> $stable(avs_readdata))
      else $error("read data moved");
   AST_RD_UPPER: assert property (avs_readdata[31:13] == '0)
      else $error("undefined read bits set");
   AST_OUT_HOLD: assert property (out_valid && !out_ready
      |=> out_valid && $stable(out_sample)) else $error("output dropped");
   AST_FULL_VALID: assert property (!in_ready |-> out_valid)
      else $error("refused while empty");
endmodule : iqc_top_props

bind iqc_top iqc_top_props u_props (.ref_clk, .rstn, .avs_read,
   .avs_write, .avs_readdata, .avs_waitrequest, .in_valid, .in_ready,
   .out_valid, .out_ready, .out_sample);

//--- testbench/iqc_sink.sv
`timescale 1ns/100ps
// ---------------
// Downstream sink
// ---------------
module iqc_sink
   import iqc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic stall,
   input wire logic out_valid,
   input wire iqc_sample_t out_sample,
   output logic out_ready
);
   iqc_sample_t got_q[$];
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         out_ready <= 1'b0;
      end else begin
         out_ready <= !stall;
         if (out_valid && out_ready) got_q.push_back(out_sample);
      end
   end
endmodule : iqc_sink

//--- testbench/tb_top.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
$display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_top
   import iqc_pkg::*;
;
   localparam logic [7:0] RV0[12] = '{8'h00, 8'h00, 8'hff, 8'h07, 8'h00,
      8'h00, 8'h00, 8'h00, 8'hff, 8'h07, 8'h00, 8'h00};
   logic ref_clk = 0, rstn = 0, avs_read = 0, avs_write = 0;
   logic in_valid = 0, stall = 0, en = 1;
   logic avs_waitrequest, in_ready, out_valid, out_ready;
   logic [ADDR_W-1:0] avs_address = '0;
   logic [31:0] avs_writedata = '0, avs_readdata, rdv;
   logic [3:0] avs_byteenable = 4'h1;
   iqc_sample_t in_sample = '0, out_sample, exp_q[$];
   int fails = 0, comparisons = 0, n, k;
   int cph_i, cph_q, cg_i = 2047, cg_q = 2047, co_i, co_q;
   iqc_top u_dut (.ref_clk, .rstn, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
      .in_valid, .in_ready, .in_sample, .out_valid, .out_ready, .out_sample);
   iqc_sink u_sink (.ref_clk, .rstn, .stall, .out_valid, .out_sample,
      .out_ready);
   initial forever #4 ref_clk = ~ref_clk;
   task automatic stop_test();
      if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   task automatic tmo();
      fails++;
      stop_test();
   endtask : tmo
   // -------------
   // Expected math
   // -------------
   function automatic int sat(int v);
      return v > 32767 ? 32767 : (v < -32768 ? -32768 : v);
   endfunction : sat
   function automatic iqc_sample_t model(int i, int q);
      int i1, q1;
      if (!en) return {16'(i), 16'(q)};
      i1 = sat(i + ((q * cph_i) >>> 11));
      q1 = sat(q + ((i * cph_q) >>> 11));
      i1 = sat(sat((i1 * cg_i) >>> 11) + co_i * 16);
      q1 = sat(sat((q1 * cg_q) >>> 11) + co_q * 16);
      return {16'(i1), 16'(q1)};
   endfunction : model
   // ----------
   // Bus tasks
   // ----------
   task automatic bus(input logic wr, input logic [5:0] a,
      input logic [7:0] d);
      int j;
      logic w;
      @(posedge ref_clk);
      avs_write <= wr;
      avs_read <= !wr;
      avs_address <= a;
      avs_writedata <= {24'h00_0000, d};
      for (j = 0; j < 50; j++) begin
         @(negedge ref_clk);
         w = avs_waitrequest;
         rdv = avs_readdata;
         @(posedge ref_clk);
         if (w === 1'b0) break;
      end
      if (j == 50) tmo();
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task automatic rdc(input logic [5:0] a, input logic [31:0] e);
      bus(1'b0, a, 8'h00);
      `CHK("readdata", e, rdv)
   endtask : rdc
   task automatic cfg(input logic [8:0] pi, pq,
      input logic [11:0] gi, gq, oi, oq);
      logic [7:0] rv[12];
      int j;
      rv = '{pi[7:0], {7'h00, pi[8]}, gi[7:0], {4'h0, gi[11:8]}, oi[7:0],
         {4'h0, oi[11:8]}, pq[7:0], {7'h00, pq[8]}, gq[7:0],
         {4'h0, gq[11:8]}, oq[7:0], {4'h0, oq[11:8]}};
      for (j = 0; j < 12; j++) begin
         if (j == 0 || j == 6) wr(IDX_I_PHASE_LOW + 6'(j) + rv[j + 1][0],
            rv[j]);
         else if (j != 1 && j != 7) wr(IDX_I_PHASE_LOW + 6'(j), rv[j]);
      end
      for (j = 0; j < 12; j++) rdc(IDX_I_PHASE_LOW + 6'(j), 32'(rv[j]));
      cph_i = $signed(pi);
      cph_q = $signed(pq);
      cg_i = $signed(gi);
      cg_q = $signed(gq);
      co_i = $signed(oi);
      co_q = $signed(oq);
   endtask : cfg
   // ------------
   // Stream tasks
   // ------------
   task automatic send(input int i, input int q);
      int j;
      logic r;
      @(posedge ref_clk);
      in_valid <= 1'b1;
      in_sample <= {16'(i), 16'(q)};
      exp_q.push_back(model(i, q));
      for (j = 0; j < 200; j++) begin
         @(negedge ref_clk);
         r = in_ready;
         @(posedge ref_clk);
         if (r === 1'b1) break;
      end
      if (j == 200) tmo();
      in_valid <= 1'b0;
   endtask : send
   task automatic drain();
      int j;
      iqc_sample_t e, g;
      for (j = 0; j < 300 && u_sink.got_q.size() < exp_q.size(); j++)
         @(posedge ref_clk);
      if (j == 300) tmo();
      while (exp_q.size() > 0) begin
         e = exp_q.pop_front();
         g = u_sink.got_q.pop_front();
         `CHK("sample", e, g)
      end
   endtask : drain
   // --------
   // Sequence
   // --------
   initial begin
      repeat (16) @(posedge ref_clk);
      rstn <= 1'b1;
      for (k = 0; k < 12; k++) rdc(IDX_I_PHASE_LOW + 6'(k), 32'(RV0[k]));
      rdc(IDX_CONTROL, 32'h0000_0001);
      wr(IDX_I_GAIN_HIGH, 8'hf3);
      rdc(IDX_I_GAIN_HIGH, 32'h0000_0003);
      avs_byteenable <= 4'h0;
      wr(IDX_I_GAIN_LOW, 8'h12);
      avs_byteenable <= 4'h1;
      rdc(IDX_I_GAIN_LOW, 32'h0000_00ff);
      wr(6'h10, 8'h5a);
      rdc(6'h10, 32'h0000_0000);
      cfg(9'h100, 9'h050, 12'h400, 12'h800, 12'h010, 12'hff0);
      send(12000, -8000);
      send(-300, 20000);
      drain();
      cfg(9'h0ff, 9'h1ff, 12'h7ff, 12'h7ff, 12'h7ff, 12'h800);
      send(1000, -1000);
      drain();
      bus(1'b0, IDX_STATUS, 8'h00);
      `CHK("sat", 1'b1, rdv[STAT_SAT_BIT])
      wr(IDX_STATUS, 8'h01);
      rdc(IDX_STATUS, 32'h0000_0000);
      cfg(9'h000, 9'h000, 12'h7ff, 12'h7ff, 12'h020, 12'hfe0);
      stall <= 1'b1;
      repeat (4) @(posedge ref_clk);
      for (n = 0; n < FIFO_DEPTH + 1; n++) send(n * 50, -n * 70);
      repeat (2) @(negedge ref_clk);
      `CHK("fill", 1'b0, in_ready)
      bus(1'b0, IDX_STATUS, 8'h00);
      `CHK("level", 5'h10, rdv[STAT_LEVEL_LSB +: 5])
      stall <= 1'b0;
      drain();
      wr(IDX_CONTROL, 8'h00);
      en = 1'b0;
      send(-32768, 32767);
      drain();
      stop_test();
   end
endmodule : tb_top
